//--- core/cbbc_exec.sv
// execute slice: six conditional branches and file_bit_clear, axi4-lite registers
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cbbc_exec #(
  parameter int          PC_W        = 21,
  parameter logic [11:0] STATUS_ADDR = 12'hfd8
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // instruction fetch side
  input  wire logic [15:0]             instr_word,
  input  wire logic                    instr_valid,
  output logic                         instr_taken_q,
  output logic                         flush_q,
  output logic [PC_W-1:0]              pc_q,
  output logic [1:0]                   phase_q,
  // data memory side
  output var cbbc_pkg::cbbc_dmem_req_t dmem_req_q,
  input  wire logic [7:0]              dmem_rdata
);

  // elaboration checks
  if (PC_W < 10 || PC_W > 32) begin : g_pc_w_check
    $error("PC_W must lie between 10 and 32");
  end

  // state
  cbbc_pkg::cbbc_state_t state_q;
  cbbc_pkg::cbbc_flags_t flags_q;
  logic [15:0]           ir_q;
  logic                  busy_q;
  logic                  ext_en_q;
  logic [3:0]            bank_q;
  logic [11:0]           index_q;
  logic                  status_hit_q;
  // axi holding registers
  logic                  aw_got_q;
  logic                  w_got_q;
  logic [7:0]            awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  // combinational helpers
  logic                  q1;
  logic                  q3;
  logic                  q4;
  logic                  consume;
  logic                  is_branch;
  logic                  take;
  logic                  is_clear;
  logic [11:0]           clear_addr;
  logic [7:0]            clear_src;
  logic [PC_W-1:0]       offset;
  logic                  reg_wr;
  logic                  wr_ctrl;
  logic                  wr_bank;
  logic                  wr_flags;
  logic                  wr_pc;
  logic                  wr_index;
  logic                  wr_known;
  logic [31:0]           wr_mask;
  logic [31:0]           rd_word;
  logic                  rd_known;

  // phase decode; instruction execution steps once per four aclk, the axi channels every aclk
  assign q1 = (phase_q == cbbc_pkg::CBBC_PH_Q1);
  assign q3 = (phase_q == cbbc_pkg::CBBC_PH_Q3);
  assign q4 = (phase_q == cbbc_pkg::CBBC_PH_Q4);

  // a word is taken only at Q1 of an executing cycle, never during flush
  assign consume = q1 && instr_valid && (state_q == cbbc_pkg::CBBC_ST_EXEC);

  // phase divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= cbbc_pkg::CBBC_PH_Q1;
    end else begin
      phase_q <= phase_q + 2'd1;
    end
  end

  // branch condition from the latched word
  always_comb begin
    is_branch = 1'b1;
    take      = 1'b0;
    case (ir_q[15:8])
      cbbc_pkg::CBBC_OP_CARRY_SET:   take = flags_q.c;
      cbbc_pkg::CBBC_OP_NEGATIVE:    take = flags_q.n;
      cbbc_pkg::CBBC_OP_CARRY_CLEAR: take = !flags_q.c;
      cbbc_pkg::CBBC_OP_NOT_NEG:     take = !flags_q.n;
      cbbc_pkg::CBBC_OP_NO_OVF:      take = !flags_q.ov;
      cbbc_pkg::CBBC_OP_NONZERO:     take = !flags_q.z;
      default:                       is_branch = 1'b0;
    endcase
  end

  // signed offset doubled and widened to the pc
  assign offset = {{(PC_W-9){ir_q[7]}}, ir_q[7:0], 1'b0};

  // operand address of a fresh word, resolved at Q1
  assign is_clear = (instr_word[15:12] == cbbc_pkg::CBBC_OP_BIT_CLEAR);
  always_comb begin
    if (instr_word[8]) begin
      clear_addr = {bank_q, instr_word[7:0]};
    end else if (instr_word[7:0] <= cbbc_pkg::CBBC_ACCESS_LIMIT) begin
      if (ext_en_q) begin
        clear_addr = index_q + {4'h0, instr_word[7:0]};
      end else begin
        clear_addr = {cbbc_pkg::CBBC_ACCESS_LOW, instr_word[7:0]};
      end
    end else begin
      clear_addr = {cbbc_pkg::CBBC_ACCESS_HIGH, instr_word[7:0]};
    end
  end

  // the status register lives here, so its reads never go to memory
  assign clear_src = status_hit_q ? {3'h0, flags_q} : dmem_rdata;

  // instruction latch and hand-shake pulse to fetch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_q          <= 16'h0000;
      busy_q        <= 1'b0;
      instr_taken_q <= 1'b0;
    end else begin
      instr_taken_q <= consume;
      if (consume) begin
        ir_q   <= instr_word;
        busy_q <= 1'b1;
      end else if (q4) begin
        busy_q <= 1'b0;
      end
    end
  end

  // execute / flush sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= cbbc_pkg::CBBC_ST_EXEC;
      flush_q <= 1'b0;
    end else if (q4) begin
      case (state_q)
        cbbc_pkg::CBBC_ST_EXEC: begin
          if (busy_q && is_branch && take) begin
            state_q <= cbbc_pkg::CBBC_ST_FLUSH;
            flush_q <= 1'b1;
          end
        end
        cbbc_pkg::CBBC_ST_FLUSH: begin
          state_q <= cbbc_pkg::CBBC_ST_EXEC;
          flush_q <= 1'b0;
        end
        default: begin
          state_q <= cbbc_pkg::CBBC_ST_EXEC;
          flush_q <= 1'b0;
        end
      endcase
    end
  end

  // program counter: increment at Q1, branch target written at Q4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= '0;
    end else if (wr_pc) begin
      // software reload wins so a debugger can always redirect
      pc_q <= wdata_q[PC_W-1:0];
    end else if (consume) begin
      pc_q <= pc_q + PC_W'(2);
    end else if (q4 && busy_q && is_branch && take) begin
      pc_q <= pc_q + offset;
    end
  end

  // data memory request: read visible in Q2, write visible in Q4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dmem_req_q   <= '0;
      status_hit_q <= 1'b0;
    end else begin
      dmem_req_q.rd <= 1'b0;
      dmem_req_q.wr <= 1'b0;
      if (consume && is_clear) begin
        dmem_req_q.addr <= clear_addr;
        dmem_req_q.rd   <= (clear_addr != STATUS_ADDR);
        status_hit_q    <= (clear_addr == STATUS_ADDR);
      end else if (q3 && busy_q && ir_q[15:12] == cbbc_pkg::CBBC_OP_BIT_CLEAR) begin
        dmem_req_q.wdata <= clear_src & ~(8'h01 << ir_q[11:9]);
        dmem_req_q.wr    <= !status_hit_q;
      end
    end
  end

  // flags: only software or a bit clear aimed at status change them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else if (q4 && busy_q && status_hit_q
                 && ir_q[15:12] == cbbc_pkg::CBBC_OP_BIT_CLEAR) begin
      flags_q <= dmem_req_q.wdata[4:0];
    end else if (wr_flags) begin
      flags_q <= (flags_q & ~wr_mask[4:0]) | (wdata_q[4:0] & wr_mask[4:0]);
    end
  end

  // write decode; one register write per completed aw+w pair
  assign reg_wr   = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_ctrl  = reg_wr && (awaddr_q == cbbc_pkg::CBBC_OFF_CTRL);
  assign wr_bank  = reg_wr && (awaddr_q == cbbc_pkg::CBBC_OFF_BANK);
  assign wr_flags = reg_wr && (awaddr_q == cbbc_pkg::CBBC_OFF_FLAGS);
  assign wr_pc    = reg_wr && (awaddr_q == cbbc_pkg::CBBC_OFF_PC);
  assign wr_index = reg_wr && (awaddr_q == cbbc_pkg::CBBC_OFF_INDEX);
  assign wr_known = wr_ctrl || wr_bank || wr_flags || wr_pc || wr_index;
  assign wr_mask  = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // software configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_q <= 1'b0;
      bank_q   <= cbbc_pkg::CBBC_BANK_RST;
      index_q  <= cbbc_pkg::CBBC_INDEX_RST;
    end else begin
      if (wr_ctrl && wstrb_q[0]) begin
        ext_en_q <= wdata_q[cbbc_pkg::CBBC_CTRL_EXT_BIT];
      end
      if (wr_bank && wstrb_q[0]) begin
        bank_q <= wdata_q[cbbc_pkg::CBBC_BANK_W-1:0];
      end
      if (wr_index) begin
        index_q <= (index_q & ~wr_mask[11:0]) | (wdata_q[11:0] & wr_mask[11:0]);
      end
    end
  end

  // axi write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cbbc_pkg::CBBC_RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_got_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_got_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (reg_wr) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? cbbc_pkg::CBBC_RESP_OKAY : cbbc_pkg::CBBC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // readies return only after the response, one write in flight
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read mux
  always_comb begin
    rd_word  = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      cbbc_pkg::CBBC_OFF_CTRL:  rd_word[cbbc_pkg::CBBC_CTRL_EXT_BIT] = ext_en_q;
      cbbc_pkg::CBBC_OFF_BANK:  rd_word[3:0] = bank_q;
      cbbc_pkg::CBBC_OFF_FLAGS: rd_word[4:0] = flags_q;
      cbbc_pkg::CBBC_OFF_PC:    rd_word[PC_W-1:0] = pc_q;
      cbbc_pkg::CBBC_OFF_INDEX: rd_word[11:0] = index_q;
      cbbc_pkg::CBBC_OFF_STATE: begin
        rd_word[15:0]                      = ir_q;
        rd_word[cbbc_pkg::CBBC_STATE_FLUSH] = flush_q;
      end
      default:                  rd_known = 1'b0;
    endcase
  end

  // axi read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cbbc_pkg::CBBC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_known ? cbbc_pkg::CBBC_RESP_OKAY : cbbc_pkg::CBBC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // cbbc_exec
`default_nettype wire

//--- core/cbbc_pkg.sv
// constants and types for the conditional branch / bit clear execute slice
package cbbc_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] CBBC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] CBBC_OFF_BANK  = 8'h04;
  localparam logic [7:0] CBBC_OFF_FLAGS = 8'h08;
  localparam logic [7:0] CBBC_OFF_PC    = 8'h0c;
  localparam logic [7:0] CBBC_OFF_INDEX = 8'h10;
  localparam logic [7:0] CBBC_OFF_STATE = 8'h14;

  // field positions
  localparam int CBBC_CTRL_EXT_BIT   = 0;
  localparam int CBBC_STATE_FLUSH    = 16;
  localparam int CBBC_BANK_W         = 4;
  localparam int CBBC_FLAGS_W        = 5;

  // reset values
  localparam logic [3:0]  CBBC_BANK_RST  = 4'h0;
  localparam logic [11:0] CBBC_INDEX_RST = 12'h000;

  // axi responses
  localparam logic [1:0] CBBC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CBBC_RESP_SLVERR = 2'b10;

  // opcodes in the high byte of a branch word
  localparam logic [7:0] CBBC_OP_CARRY_SET   = 8'he2;
  localparam logic [7:0] CBBC_OP_NEGATIVE    = 8'he6;
  localparam logic [7:0] CBBC_OP_CARRY_CLEAR = 8'he3;
  localparam logic [7:0] CBBC_OP_NOT_NEG     = 8'he7;
  localparam logic [7:0] CBBC_OP_NO_OVF      = 8'he5;
  localparam logic [7:0] CBBC_OP_NONZERO     = 8'he1;
  // opcode nibble of file_bit_clear
  localparam logic [3:0] CBBC_OP_BIT_CLEAR   = 4'h9;

  // access bank split and its upper page
  localparam logic [7:0] CBBC_ACCESS_LIMIT = 8'h5f;
  localparam logic [3:0] CBBC_ACCESS_LOW   = 4'h0;
  localparam logic [3:0] CBBC_ACCESS_HIGH  = 4'hf;

  // phases of one instruction cycle, one aclk each
  localparam logic [1:0] CBBC_PH_Q1 = 2'd0;
  localparam logic [1:0] CBBC_PH_Q2 = 2'd1;
  localparam logic [1:0] CBBC_PH_Q3 = 2'd2;
  localparam logic [1:0] CBBC_PH_Q4 = 2'd3;

  typedef enum logic {CBBC_ST_EXEC, CBBC_ST_FLUSH} cbbc_state_t;

  // arithmetic flags, carry in bit 0
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cbbc_flags_t;

  // data memory request
  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } cbbc_dmem_req_t;

endpackage

//--- verif/cbbc_exec_monitor.sv
// assertion checker for the branch and bit clear execute slice
`timescale 1ns/100ps
`default_nettype none
module cbbc_exec_monitor #(
  parameter int          PC_W        = 21,
  parameter logic [11:0] STATUS_ADDR = 12'hfd8
) (
  // clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // fetch side
  input wire logic [15:0]              instr_word,
  input wire logic                     instr_valid,
  input wire logic                     instr_taken_q,
  input wire logic                     flush_q,
  input wire logic [PC_W-1:0]          pc_q,
  input wire logic [1:0]               phase_q,
  // data memory side
  input wire cbbc_pkg::cbbc_dmem_req_t dmem_req_q,
  input wire logic [7:0]               dmem_rdata
);
  logic [15:0]     word_q;
  logic [PC_W-1:0] tgt_q;
  logic [7:0]      rd_q;
  wire logic       take = phase_q == cbbc_pkg::CBBC_PH_Q1 && instr_valid && !flush_q;
  // expected target kept from the take, since pc moves on before the jump
  always_ff @(posedge aclk) begin
    if (take) begin
      word_q <= instr_word;
      tgt_q  <= pc_q + PC_W'(2) + {{(PC_W-9){instr_word[7]}}, instr_word[7:0], 1'b0};
    end
    if (phase_q == cbbc_pkg::CBBC_PH_Q3) rd_q <= dmem_rdata;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take; phase_q == 2'd0 && instr_valid && !flush_q; endsequence
  sequence s_clear_hi;
    s_take ##0 (instr_word[15:12] == 4'h9 && !instr_word[8] && instr_word[7:0] > 8'h5f
      && {4'hf, instr_word[7:0]} != STATUS_ADDR);
  endsequence
  property p_phase; $past(aresetn) |-> phase_q == $past(phase_q) + 2'd1; endproperty
  property p_take; s_take |=> instr_taken_q && pc_q == $past(pc_q) + PC_W'(2); endproperty
  property p_target; $rose(flush_q) |-> phase_q == 2'd0 && pc_q == tgt_q; endproperty
  property p_flush; $rose(flush_q) |-> flush_q [*4] ##1 !flush_q; endproperty
  property p_noflush; s_take ##0 (instr_word[15:12] != 4'he) |-> ##4 !flush_q; endproperty
  property p_rd; dmem_req_q.rd |-> phase_q == 2'd1; endproperty
  property p_wr;
    dmem_req_q.wr |-> phase_q == 2'd3 && $past(dmem_req_q.rd, 2)
      && dmem_req_q.addr == $past(dmem_req_q.addr, 2);
  endproperty
  property p_data; dmem_req_q.wr |-> dmem_req_q.wdata == (rd_q & ~(8'h01 << word_q[11:9])); endproperty
  property p_bank_hi; s_clear_hi |=> dmem_req_q.rd && dmem_req_q.addr == {4'hf, word_q[7:0]}; endproperty
  a_phase: assert property (p_phase) else $error("phase did not advance by one");
  a_take: assert property (p_take) else $error("take pulse or pc step wrong");
  a_target: assert property (p_target) else $error("branch target wrong");
  a_flush: assert property (p_flush) else $error("flush cycle not four clocks");
  a_noflush: assert property (p_noflush) else $error("flush after non branch");
  a_rd: assert property (p_rd) else $error("memory read outside second phase");
  a_wr: assert property (p_wr) else $error("memory write misplaced");
  a_data: assert property (p_data) else $error("written byte wrong");
  a_bank_hi: assert property (p_bank_hi) else $error("upper access page address wrong");
endmodule // cbbc_exec_monitor
bind cbbc_exec cbbc_exec_monitor #(.PC_W(PC_W), .STATUS_ADDR(STATUS_ADDR)) cbbc_exec_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_taken_q(instr_taken_q), .flush_q(flush_q), .pc_q(pc_q), .phase_q(phase_q),
  .dmem_req_q(dmem_req_q), .dmem_rdata(dmem_rdata));
`default_nettype wire

//--- verif/cbbc_dmem_model.sv
// data memory partner model for the execute slice
`timescale 1ns/100ps
`default_nettype none
module cbbc_dmem_model (
  // clock
  input  wire logic                     aclk,
  // request and read data
  input  wire cbbc_pkg::cbbc_dmem_req_t dmem_req_q,
  output logic [7:0]                    dmem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] out_q;
  logic       vld_q;
  // pattern repeats every 256 bytes, so only a wrong low address byte shows as a wrong byte
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'ha5;
    out_q = 8'h00;
    vld_q = 1'b0;
  end
  // read data valid one cycle only, writes land on the strobe edge
  always @(posedge aclk) begin
    vld_q <= dmem_req_q.rd;
    if (dmem_req_q.rd) out_q <= mem[dmem_req_q.addr];
    if (dmem_req_q.wr) mem[dmem_req_q.addr] <= dmem_req_q.wdata;
  end
  // stale data inverted so it never passes for a good read
  assign dmem_rdata = vld_q ? out_q : ~out_q;
endmodule // cbbc_dmem_model
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the branch and bit clear execute slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic        aclk, aresetn, instr_valid, instr_taken_q, flush_q;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dmem_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, phase_q, r;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] instr_word;
  logic [20:0] pc_q;
  int          mismatches, compares;
  cbbc_pkg::cbbc_dmem_req_t dmem_req_q;
  logic [7:0]  ops [6] = '{8'he2, 8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
  logic [4:0]  bits [6] = '{5'h01, 5'h10, 5'h01, 5'h10, 5'h08, 5'h04};
  logic        pol [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  cbbc_exec #(.PC_W(21), .STATUS_ADDR(12'hfd8)) cbbc_exec_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_taken_q(instr_taken_q), .flush_q(flush_q), .pc_q(pc_q),
    .phase_q(phase_q), .dmem_req_q(dmem_req_q), .dmem_rdata(dmem_rdata));
  cbbc_dmem_model cbbc_dmem_model_i (
    .aclk(aclk), .dmem_req_q(dmem_req_q), .dmem_rdata(dmem_rdata));
  // clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // axi4-lite write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready) begin ta = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!tw && s_axi_wready) begin tw = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask
  // axi4-lite read and compare
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  // offer one word and hold it until taken
  task automatic ex(input logic [15:0] w);
    instr_word  <= w;
    instr_valid <= 1'b1;
    do @(posedge aclk); while (!instr_taken_q);
    instr_valid <= 1'b0;
  endtask
  // branch from 0x1000 with given flags
  task automatic br(input logic [7:0] op, input logic [4:0] fl, input logic tk, input logic [7:0] n);
    wr(cbbc_pkg::CBBC_OFF_FLAGS, {27'h0, fl}, r);
    wr(cbbc_pkg::CBBC_OFF_PC, 32'h0000_1000, r);
    ex({op, n});
    repeat (3) @(posedge aclk);
    `CHK("flush", tk, flush_q)
    repeat (4) @(posedge aclk);
    `CHK("pc", tk ? 21'h1002 + {{12{n[7]}}, n, 1'b0} : 21'h1002, pc_q)
    `CHK("flush end", 1'b0, flush_q)
    rc(cbbc_pkg::CBBC_OFF_FLAGS, {27'h0, fl}, 2'b00);
  endtask
  // bit clear and check the memory cell
  task automatic clr(input logic [15:0] w, input logic [11:0] a);
    ex(w);
    repeat (3) @(posedge aclk);
    `CHK("mem", (a[7:0] ^ 8'ha5) & ~(8'h01 << w[11:9]), cbbc_dmem_model_i.mem[a])
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    mismatches++;
    wrap_up;
  end
  initial begin
    {aresetn, instr_valid, instr_word, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb  = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) rc(8'(a), 32'h0, 2'b00);
    rc(8'h18, 32'h0, cbbc_pkg::CBBC_RESP_SLVERR);
    wr(8'h18, 32'h0000_0001, r);
    `CHK("bresp", cbbc_pkg::CBBC_RESP_SLVERR, r)
    for (int i = 0; i < 6; i++) begin
      for (int s = 0; s < 2; s++) begin
        br(ops[i], s ? bits[i] : 5'h1f ^ bits[i], (s == 1) == pol[i], s ? 8'h80 : 8'h7f);
      end
    end
    clr(16'h9020, 12'h020);
    clr(16'h9e80, 12'hf80);
    wr(cbbc_pkg::CBBC_OFF_BANK, 32'hffff_fff5, r);
    `CHK("bresp", cbbc_pkg::CBBC_RESP_OKAY, r)
    rc(cbbc_pkg::CBBC_OFF_BANK, 32'h0000_0005, 2'b00);
    clr(16'h9733, 12'h533);
    wr(cbbc_pkg::CBBC_OFF_CTRL, 32'h0000_0001, r);
    wr(cbbc_pkg::CBBC_OFF_INDEX, 32'h0000_0100, r);
    clr(16'h9a10, 12'h110);
    clr(16'h945f, 12'h15f);
    clr(16'h9260, 12'hf60);
    wr(cbbc_pkg::CBBC_OFF_FLAGS, 32'h0000_001f, r);
    ex(16'h96d8);
    repeat (4) @(posedge aclk);
    rc(cbbc_pkg::CBBC_OFF_FLAGS, 32'h0000_0017, 2'b00);
    `CHK("status cell", 8'hd8 ^ 8'ha5, cbbc_dmem_model_i.mem[12'hfd8])
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
